// ==== design/ulm_pkg.sv ====
package ulm_pkg;

	// ****************************************************************
	// Register offsets (byte addresses on the plain register port)
	// ****************************************************************
	localparam logic [5:0] OFS_MODE_ONE = 6'h00;
	localparam logic [5:0] OFS_MODE_TWO = 6'h04;
	localparam logic [5:0] OFS_STATUS_CMD = 6'h08;
	localparam logic [5:0] OFS_BUFFER = 6'h0C;
	localparam logic [5:0] OFS_VECTOR = 6'h10;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int PM_HI = 4;
	localparam int PM_LO = 3;
	localparam int PT_BIT = 2;
	localparam int CM_HI = 7;
	localparam int CM_LO = 6;
	localparam logic [1:0] PM_MULTIDROP = 2'h3;

	// Command bits (write to the status/command location)
	localparam int CMD_RX_EN = 0;
	localparam int CMD_RX_DIS = 1;
	localparam int CMD_TX_EN = 2;
	localparam int CMD_TX_DIS = 3;

	// Status bits
	localparam int ST_RX_READY = 0;
	localparam int ST_TX_READY = 2;
	localparam int ST_TX_EMPTY = 3;
	localparam int ST_OVERRUN = 4;
	localparam int ST_PARITY = 5;
	localparam int ST_FRAME = 6;
	localparam int ST_BREAK = 7;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:0] MODE_ONE_RST = 8'h00;
	localparam logic [7:0] MODE_TWO_RST = 8'h00;
	localparam logic [7:0] VECTOR_RST = 8'h0F;

	// Channel operating modes
	typedef enum logic [1:0] {CHAN_NORMAL, CHAN_ECHO, CHAN_LOCAL, CHAN_REMOTE} ulm_chan_mode_t;

endpackage

// ==== design/ulm_channel_modes.sv ====
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module ulm_channel_modes
(
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Register port
	input wire logic [5:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdData,
	// Interrupt acknowledge
	input wire logic iackReq,
	output logic iackAck,
	output logic [7:0] iackVector,
	// Serial pins
	input wire logic rxdPin,
	output logic txdPin,
	// Bit clock ticks from the baud generators
	input wire logic rxClkTick,
	input wire logic txClkTick,
	// Transmitter engine
	input wire logic txEngBit,
	input wire logic txEngEmpty,
	input wire logic txEngReady,
	output logic txEngLoad,
	output logic [7:0] txEngData,
	output logic txEngClkTick,
	output logic txEngEnable,
	output logic txParityGen,
	output logic txTagSlot,
	output logic txTagValue,
	// Receiver engine
	output logic rxEngBit,
	output logic rxEngClkTick,
	output logic rxParityCheck,
	input wire logic rxCharValid,
	input wire logic [7:0] rxCharData,
	input wire logic rxCharSlot,
	input wire logic rxParityErr,
	input wire logic rxFrameErr,
	input wire logic rxBreakDet,
	input wire logic rxStartDet,
	input wire logic rxOverrun,
	// Receive FIFO
	output logic fifoPush,
	output logic [7:0] fifoData,
	output logic fifoStatPe,
	output logic fifoStatFe,
	output logic fifoStatRb,
	output logic fifoPop,
	input wire logic fifoNotEmpty,
	input wire logic [7:0] fifoTopData,
	input wire logic fifoTopPe,
	input wire logic fifoTopFe,
	input wire logic fifoTopRb
);

	// ****************************************************************
	// Registers and decode
	// ****************************************************************
	logic [7:0] modeOneReg;
	logic [7:0] modeTwoReg;
	logic [7:0] vectorReg;
	logic rxEnabledReg;
	logic txEnabledReg;
	logic breakHoldReg;
	logic echoBitReg;
	logic [7:0] statusByte;
	logic [7:0] readNext;
	ulm_pkg::ulm_chan_mode_t chanMode;
	logic multidrop;
	logic loopsBack;
	logic wrByte;
	logic txEmptyFlag;
	logic txReadyFlag;
	logic pushCond;

	// Address match helper shared by the read and write paths
	function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
		hit = (a == ofs);
	endfunction

	// Mode decode is combinational so a new setting applies mid-character
	assign chanMode = ulm_pkg::ulm_chan_mode_t'(modeTwoReg[ulm_pkg::CM_HI:ulm_pkg::CM_LO]);
	assign multidrop = (modeOneReg[ulm_pkg::PM_HI:ulm_pkg::PM_LO] == ulm_pkg::PM_MULTIDROP);
	assign loopsBack = (chanMode == ulm_pkg::CHAN_ECHO) || (chanMode == ulm_pkg::CHAN_REMOTE);
	assign wrByte = regWr; // Upper lanes ignored, only bits 7:0 are used

	// ****************************************************************
	// Configuration registers
	// ****************************************************************

	// Mode registers; the status location is read-only so writes there are commands only
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			modeOneReg <= ulm_pkg::MODE_ONE_RST;
			modeTwoReg <= ulm_pkg::MODE_TWO_RST;
		end
		else if (wrByte && hit(regAddr, ulm_pkg::OFS_MODE_ONE))
			modeOneReg <= regWrData[7:0];
		else if (wrByte && hit(regAddr, ulm_pkg::OFS_MODE_TWO))
			modeTwoReg <= regWrData[7:0];
	end

	// Vector register; left at its reset value the handler lands on a spurious vector
	always_ff @(posedge clock)
	begin
		if (!rstn)
			vectorReg <= ulm_pkg::VECTOR_RST;
		else if (wrByte && hit(regAddr, ulm_pkg::OFS_VECTOR))
			vectorReg <= regWrData[7:0];
	end

	// Enable commands; enable wins if software sets both bits at once
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			rxEnabledReg <= 1'b0;
			txEnabledReg <= 1'b0;
		end
		else if (wrByte && hit(regAddr, ulm_pkg::OFS_STATUS_CMD))
		begin
			if (regWrData[ulm_pkg::CMD_RX_EN])
				rxEnabledReg <= 1'b1;
			else if (regWrData[ulm_pkg::CMD_RX_DIS])
				rxEnabledReg <= 1'b0;
			if (regWrData[ulm_pkg::CMD_TX_EN])
				txEnabledReg <= 1'b1;
			else if (regWrData[ulm_pkg::CMD_TX_DIS])
				txEnabledReg <= 1'b0;
		end
	end

	// ****************************************************************
	// Read path and status
	// ****************************************************************

	// Transmitter flags are dead while the transmitter is bypassed
	assign txEmptyFlag = txEngEmpty && !loopsBack;
	assign txReadyFlag = txEngReady && txEnabledReg && !loopsBack;

	// Status byte; remote loop hides received data and all error status
	always_comb
	begin
		statusByte = 8'h00;
		statusByte[ulm_pkg::ST_TX_EMPTY] = txEmptyFlag;
		statusByte[ulm_pkg::ST_TX_READY] = txReadyFlag;
		if (chanMode != ulm_pkg::CHAN_REMOTE)
		begin
			statusByte[ulm_pkg::ST_RX_READY] = fifoNotEmpty;
			statusByte[ulm_pkg::ST_OVERRUN] = rxOverrun && fifoNotEmpty;
			statusByte[ulm_pkg::ST_PARITY] = fifoTopPe && fifoNotEmpty; // Tag in multidrop
			statusByte[ulm_pkg::ST_FRAME] = fifoTopFe && fifoNotEmpty;
			statusByte[ulm_pkg::ST_BREAK] = fifoTopRb && fifoNotEmpty;
		end
	end

	// Read mux; unmapped locations return zero
	always_comb
	begin
		readNext = 8'h00;
		if (hit(regAddr, ulm_pkg::OFS_MODE_ONE))
			readNext = modeOneReg;
		else if (hit(regAddr, ulm_pkg::OFS_MODE_TWO))
			readNext = modeTwoReg;
		else if (hit(regAddr, ulm_pkg::OFS_STATUS_CMD))
			readNext = statusByte;
		else if (hit(regAddr, ulm_pkg::OFS_BUFFER) && chanMode != ulm_pkg::CHAN_REMOTE)
			readNext = fifoTopData;
		else if (hit(regAddr, ulm_pkg::OFS_VECTOR))
			readNext = vectorReg;
	end

	// Read data lands the next cycle with no stall possible
	always_ff @(posedge clock)
	begin
		if (!rstn)
			regRdData <= 8'h00;
		else if (regRd)
			regRdData <= readNext;
		else
			regRdData <= 8'h00;
	end

	// Reading the buffer pops the FIFO top
	always_ff @(posedge clock)
	begin
		if (!rstn)
			fifoPop <= 1'b0;
		else
			fifoPop <= regRd && hit(regAddr, ulm_pkg::OFS_BUFFER) && fifoNotEmpty &&
				chanMode != ulm_pkg::CHAN_REMOTE;
	end

	// ****************************************************************
	// Interrupt acknowledge
	// ****************************************************************

	// Vector answered one cycle after the acknowledge strobe
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			iackAck <= 1'b0;
			iackVector <= 8'h00;
		end
		else
		begin
			iackAck <= iackReq;
			iackVector <= iackReq ? vectorReg : 8'h00;
		end
	end

	// ****************************************************************
	// Transmit path from the processor
	// ****************************************************************

	// Buffer writes go to the transmitter only when it is not bypassed
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			txEngLoad <= 1'b0;
			txEngData <= 8'h00;
		end
		else
		begin
			txEngLoad <= wrByte && hit(regAddr, ulm_pkg::OFS_BUFFER) && txEnabledReg &&
				!loopsBack;
			if (wrByte && hit(regAddr, ulm_pkg::OFS_BUFFER))
				txEngData <= regWrData[7:0];
		end
	end

	// Framing controls; multidrop replaces parity with the tag bit
	assign txEngEnable = txEnabledReg;
	assign txParityGen = !multidrop && (chanMode != ulm_pkg::CHAN_REMOTE);
	assign txTagSlot = multidrop;
	assign txTagValue = modeOneReg[ulm_pkg::PT_BIT]; // Polarity picks address or data
	assign rxParityCheck = !multidrop && (chanMode != ulm_pkg::CHAN_REMOTE);

	// ****************************************************************
	// Serial routing
	// ****************************************************************

	// Clock ticks follow the looping mode
	assign rxEngClkTick = (chanMode == ulm_pkg::CHAN_LOCAL) ? txClkTick : rxClkTick;
	assign txEngClkTick = (chanMode == ulm_pkg::CHAN_REMOTE) ? rxClkTick : txClkTick;

	// Break hold: a break keeps the echoed line low until a fresh start bit
	always_ff @(posedge clock)
	begin
		if (!rstn)
			breakHoldReg <= 1'b0;
		else if (rxBreakDet && loopsBack)
			breakHoldReg <= 1'b1; // A break in the start cycle still holds
		else if (rxStartDet)
			breakHoldReg <= 1'b0;
	end

	// Echo sampler: bits are retaken on the receiver clock, parity and stops untouched
	always_ff @(posedge clock)
	begin
		if (!rstn)
			echoBitReg <= 1'b1;
		else if (breakHoldReg && loopsBack)
			echoBitReg <= 1'b0;
		else if (rxClkTick)
			echoBitReg <= rxdPin;
	end

	// Pin and receiver inputs registered; one cycle of lag is far below a bit time
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			txdPin <= 1'b1;
			rxEngBit <= 1'b1;
		end
		else
		begin
			case (chanMode)
				ulm_pkg::CHAN_ECHO, ulm_pkg::CHAN_REMOTE:
				begin
					txdPin <= echoBitReg;
					rxEngBit <= rxdPin;
				end
				ulm_pkg::CHAN_LOCAL:
				begin
					txdPin <= 1'b1;
					rxEngBit <= txEngBit;
				end
				default:
				begin
					txdPin <= txEngBit;
					rxEngBit <= rxdPin;
				end
			endcase
		end
	end

	// ****************************************************************
	// Receive FIFO loading
	// ****************************************************************

	// Multidrop keeps addresses even with the receiver off; remote loop keeps nothing
	always_comb
	begin
		pushCond = 1'b0;
		if (rxCharValid && chanMode != ulm_pkg::CHAN_REMOTE)
		begin
			if (multidrop)
				pushCond = rxEnabledReg || rxCharSlot;
			else
				pushCond = rxEnabledReg;
		end
	end

	// Character and its status enter the FIFO together
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			fifoPush <= 1'b0;
			fifoData <= 8'h00;
			fifoStatPe <= 1'b0;
			fifoStatFe <= 1'b0;
			fifoStatRb <= 1'b0;
		end
		else
		begin
			fifoPush <= pushCond;
			if (pushCond)
			begin
				fifoData <= rxCharData;
				fifoStatPe <= multidrop ? rxCharSlot : rxParityErr;
				fifoStatFe <= rxFrameErr;
				fifoStatRb <= rxBreakDet;
			end
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	a_local_mark_pin: assert property ((chanMode == ulm_pkg::CHAN_LOCAL) |=> txdPin)
		else $error("txd not marking in local loop");
	a_local_rx_route: assert property ((chanMode == ulm_pkg::CHAN_LOCAL) |=>
		(rxEngBit == $past(txEngBit)))
		else $error("receiver not fed from transmitter");
	a_local_rx_clock: assert property ((chanMode == ulm_pkg::CHAN_LOCAL) |->
		(rxEngClkTick == txClkTick))
		else $error("receiver clock not transmitter clock");
	a_echo_tx_flags: assert property (loopsBack |-> (statusByte[3:2] == 2'b00))
		else $error("transmitter flags active while bypassed");
	a_bypass_tx_block: assert property ((regWr && loopsBack) |=> !txEngLoad)
		else $error("processor reached bypassed transmitter");
	// Status is combinational, so it is judged in the remote cycle itself; a push
	// follows one cycle later from the same mode
	a_remote_no_push: assert property ((chanMode == ulm_pkg::CHAN_REMOTE) |->
		(statusByte == 8'h00) ##1 !fifoPush)
		else $error("remote loop exposed received data");
	a_md_drop_data: assert property ((multidrop && !rxEnabledReg && rxCharValid &&
		!rxCharSlot) |=> !fifoPush)
		else $error("data character kept with receiver off");
	a_md_keep_all: assert property ((multidrop && rxEnabledReg && rxCharValid &&
		chanMode == ulm_pkg::CHAN_NORMAL) |=> fifoPush && (fifoStatPe == $past(rxCharSlot)))
		else $error("multidrop character lost or tag misplaced");
	// The pin follows the mode of the cycle in between, not of the cycle it is seen in
	a_break_echo_low: assert property ((breakHoldReg && loopsBack && !rxStartDet) |=> ##1
		(!txdPin || !$past(loopsBack)))
		else $error("break not echoed");
	a_echo_resend: assert property ((loopsBack && rxClkTick && !breakHoldReg) |=> ##1
		(txdPin == $past(rxdPin, 2) || !$past(loopsBack)))
		else $error("received bit not resent");
	a_reserved_zero: assert property ((regRd && regAddr > ulm_pkg::OFS_VECTOR) |=>
		(regRdData == 8'h00))
		else $error("reserved location read nonzero");
	a_status_wr_ignored: assert property ((regWr && hit(regAddr, ulm_pkg::OFS_STATUS_CMD)) |=>
		$stable(modeOneReg) && $stable(modeTwoReg) && $stable(vectorReg))
		else $error("status write altered a register");
	a_iack_vector: assert property (iackReq |=> iackAck && (iackVector == $past(vectorReg)))
		else $error("wrong vector on acknowledge");

	c_echo_char: cover property ((chanMode == ulm_pkg::CHAN_ECHO) && rxCharValid ##1 fifoPush);
	c_md_address: cover property (multidrop && !rxEnabledReg && rxCharSlot && rxCharValid);
	c_local_load: cover property ((chanMode == ulm_pkg::CHAN_LOCAL) ##0 txEngLoad);
	c_iack: cover property (iackReq ##1 iackAck);

endmodule // ulm_channel_modes
`default_nettype wire

// ==== testbench/ulm_far_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// *****
// Far side: receive store, transmitter stub, remote station line
// *****
module ulm_far_model
(
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Receive store
	input wire logic fifoPush,
	input wire logic [7:0] fifoData,
	input wire logic fifoStatPe,
	input wire logic fifoStatFe,
	input wire logic fifoStatRb,
	input wire logic fifoPop,
	output logic fifoNotEmpty,
	output logic [7:0] fifoTopData,
	output logic fifoTopPe,
	output logic fifoTopFe,
	output logic fifoTopRb,
	// Transmitter engine
	output logic txEngBit,
	output logic txEngEmpty,
	output logic txEngReady,
	// Remote station line and baud ticks
	output logic rxdPin,
	output logic rxClkTick,
	output logic txClkTick
);
	logic [10:0] store_reg;
	logic full_reg;
	logic [7:0] lfsr_reg;
	logic [3:0] count_reg;

	// One-deep store; when empty it shows the inverse of its last word,
	// so a stale character can never pass for a fresh one
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			full_reg <= 1'b0;
			store_reg <= 11'h0AA;
		end
		else if (fifoPush)
		begin
			full_reg <= 1'b1;
			store_reg <= {fifoStatPe, fifoStatFe, fifoStatRb, fifoData};
		end
		else if (fifoPop)
			full_reg <= 1'b0;
	end
	assign fifoNotEmpty = full_reg;
	assign {fifoTopPe, fifoTopFe, fifoTopRb, fifoTopData} = full_reg ? store_reg : ~store_reg;

	// Line pattern changes every cycle; receiver tick every 4 cycles, transmitter tick every 8, never in the same cycle
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			lfsr_reg <= 8'h5B;
			count_reg <= 4'h0;
		end
		else
		begin
			lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
			count_reg <= count_reg + 4'h1;
		end
	end
	assign rxdPin = lfsr_reg[0];
	assign rxClkTick = count_reg[1:0] == 2'h0;
	assign txClkTick = count_reg[2:0] == 3'h5;

	// Transmitter stub always ready and empty; its bit toggles each cycle
	assign txEngBit = count_reg[0];
	assign txEngEmpty = 1'b1;
	assign txEngReady = 1'b1;
endmodule // ulm_far_model
`default_nettype wire

// ==== testbench/uart_loop_multidrop_modes_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module uart_loop_multidrop_modes_bench;
	// *****
	// Stimulus, notes of expected results and checking
	// *****
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic [5:0] regAddr = 6'h00;
	logic [31:0] regWrData = 32'h0;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic iackReq = 1'b0;
	logic rxCharValid = 1'b0;
	logic [7:0] rxCharData = 8'h00;
	logic rxCharSlot = 1'b0;
	logic rxParityErr = 1'b0;
	logic rxFrameErr = 1'b0;
	logic rxBreakDet = 1'b0;
	logic rxStartDet = 1'b0;
	logic rxOverrun = 1'b0;
	wire logic [7:0] regRdData, iackVector, txEngData, fifoData, fifoTopData;
	wire logic iackAck, txdPin, rxdPin, rxClkTick, txClkTick, txEngBit, txEngEmpty, txEngReady;
	wire logic txEngLoad, txEngClkTick, txEngEnable, txParityGen, txTagSlot, txTagValue;
	wire logic rxEngBit, rxEngClkTick, rxParityCheck, fifoPush, fifoStatPe, fifoStatFe;
	wire logic fifoStatRb, fifoPop, fifoNotEmpty, fifoTopPe, fifoTopFe, fifoTopRb;
	logic [31:0] rdQ[$], pushQ[$], loadQ[$], iackQ[$];
	int mismatches = 0;
	int comparisons = 0;
	int cycles = 0;
	int seed = 29;
	logic [31:0] rnd;
	logic [7:0] lastCh;
	logic rdDly = 1'b0;
	logic [1:0] m;

	ulm_channel_modes u_dut
	(
		.clock(clock), .rstn(rstn),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData),
		.iackReq(iackReq), .iackAck(iackAck), .iackVector(iackVector),
		.rxdPin(rxdPin), .txdPin(txdPin), .rxClkTick(rxClkTick), .txClkTick(txClkTick),
		.txEngBit(txEngBit), .txEngEmpty(txEngEmpty), .txEngReady(txEngReady),
		.txEngLoad(txEngLoad), .txEngData(txEngData), .txEngClkTick(txEngClkTick),
		.txEngEnable(txEngEnable), .txParityGen(txParityGen), .txTagSlot(txTagSlot),
		.txTagValue(txTagValue),
		.rxEngBit(rxEngBit), .rxEngClkTick(rxEngClkTick), .rxParityCheck(rxParityCheck),
		.rxCharValid(rxCharValid), .rxCharData(rxCharData), .rxCharSlot(rxCharSlot),
		.rxParityErr(rxParityErr), .rxFrameErr(rxFrameErr), .rxBreakDet(rxBreakDet),
		.rxStartDet(rxStartDet), .rxOverrun(rxOverrun),
		.fifoPush(fifoPush), .fifoData(fifoData), .fifoStatPe(fifoStatPe),
		.fifoStatFe(fifoStatFe), .fifoStatRb(fifoStatRb), .fifoPop(fifoPop),
		.fifoNotEmpty(fifoNotEmpty), .fifoTopData(fifoTopData), .fifoTopPe(fifoTopPe),
		.fifoTopFe(fifoTopFe), .fifoTopRb(fifoTopRb)
	);
	ulm_far_model u_far
	(
		.clock(clock), .rstn(rstn),
		.fifoPush(fifoPush), .fifoData(fifoData), .fifoStatPe(fifoStatPe),
		.fifoStatFe(fifoStatFe), .fifoStatRb(fifoStatRb), .fifoPop(fifoPop),
		.fifoNotEmpty(fifoNotEmpty), .fifoTopData(fifoTopData), .fifoTopPe(fifoTopPe),
		.fifoTopFe(fifoTopFe), .fifoTopRb(fifoTopRb),
		.txEngBit(txEngBit), .txEngEmpty(txEngEmpty), .txEngReady(txEngReady),
		.rxdPin(rxdPin), .rxClkTick(rxClkTick), .txClkTick(txClkTick)
	);

	always #50 clock = ~clock;

	// Note layout: mask in the upper half, expected value in the lower
	task automatic cmpV(input logic [15:0] got, input logic [31:0] e);
		comparisons++;
		if ((got & e[31:16]) !== e[15:0])
		begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, e[15:0]);
		end
	endtask
	task automatic cmpBit(input logic got, input logic e);
		cmpV({15'h0, got}, {16'h0001, 15'h0, e});
	endtask
	// One bus cycle; upper write lanes carry junk that must be ignored
	task bus(input logic w, input logic [5:0] a, input logic [7:0] d, input logic [7:0] k);
		@(posedge clock);
		rnd = $random(seed);
		regAddr <= a;
		regWrData <= {rnd[31:8], d};
		regWr <= w;
		regRd <= !w;
		if (!w)
			rdQ.push_back({8'h00, k, 8'h00, d});
		@(posedge clock);
		regWr <= 1'b0;
		regRd <= 1'b0;
	endtask
	task iack(input logic [7:0] v);
		@(posedge clock);
		iackReq <= 1'b1;
		iackQ.push_back({16'h00FF, 8'h00, v});
		@(posedge clock);
		iackReq <= 1'b0;
	endtask
	// One finished character from the receiver engine
	task chr(input logic s, input logic pe, input logic fe, input logic keep, input logic md);
		@(posedge clock);
		rnd = $random(seed);
		rxCharValid <= 1'b1;
		rxCharData <= rnd[7:0];
		rxCharSlot <= s;
		rxParityErr <= pe;
		rxFrameErr <= fe;
		if (keep)
			pushQ.push_back({16'h07FF, 5'h00, md ? s : pe, fe, 1'b0, rnd[7:0]});
		@(posedge clock);
		rxCharValid <= 1'b0;
		lastCh = rnd[7:0];
	endtask
	task give_verdict();
		$display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Each result takes the oldest note of its kind; none noted means a miss
	always @(negedge clock)
	begin
		if (rdDly)
			cmpV({8'h00, regRdData}, rdQ.size() ? rdQ.pop_front() : 32'h0000FFFF);
		rdDly = regRd;
		if (fifoPush === 1'b1)
			cmpV({5'h00, fifoStatPe, fifoStatFe, fifoStatRb, fifoData},
				pushQ.size() ? pushQ.pop_front() : 32'h0000FFFF);
		if (txEngLoad === 1'b1)
			cmpV({8'h00, txEngData}, loadQ.size() ? loadQ.pop_front() : 32'h0000FFFF);
		if (iackAck === 1'b1)
			cmpV({8'h00, iackVector}, iackQ.size() ? iackQ.pop_front() : 32'h0000FFFF);
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			give_verdict();
		end
	end

	initial
	begin
		repeat (20) @(posedge clock);
		rstn <= 1'b1;
		// Start from a quiet channel, as initialisation software would
		bus(1, ulm_pkg::OFS_STATUS_CMD, 8'h0A, 8'h00);
		// Reset values, vector, reserved and read-only places
		bus(0, ulm_pkg::OFS_MODE_ONE, 8'h00, 8'hFF);
		bus(0, ulm_pkg::OFS_MODE_TWO, 8'h00, 8'hFF);
		bus(0, ulm_pkg::OFS_VECTOR, 8'h0F, 8'hFF);
		bus(0, 6'h14, 8'h00, 8'hFF);
		bus(1, ulm_pkg::OFS_VECTOR, 8'hA5, 8'h00);
		bus(0, ulm_pkg::OFS_VECTOR, 8'hA5, 8'hFF);
		bus(1, 6'h14, 8'h77, 8'h00);
		bus(0, 6'h14, 8'h00, 8'hFF);
		iack(8'hA5);
		// Every channel mode: clock routing, parity, transmit and receive paths; pins in local loop only
		for (int i = 0; i < 4; i++)
		begin
			m = i[1:0];
			bus(1, ulm_pkg::OFS_STATUS_CMD, 8'h0A, 8'h00);
			bus(1, ulm_pkg::OFS_MODE_TWO, {m, 6'h00}, 8'h00);
			bus(0, ulm_pkg::OFS_MODE_TWO, {m, 6'h00}, 8'hFF);
			repeat (8) @(negedge clock)
			begin
				cmpBit(txEngClkTick, m == 2'h3 ? rxClkTick : txClkTick);
				cmpBit(rxEngClkTick, m == 2'h2 ? txClkTick : rxClkTick);
				cmpBit(rxParityCheck, m != 2'h3);
				cmpBit(txParityGen, m != 2'h3);
				cmpBit(txEngEnable, 1'b0);
				if (m == 2'h2)
				begin
					cmpBit(txdPin, 1'b1);
					cmpBit(rxEngBit, ~txEngBit);
				end
			end
			bus(1, ulm_pkg::OFS_STATUS_CMD, 8'h05, 8'h00);
			@(negedge clock);
			cmpBit(txEngEnable, 1'b1);
			if (!m[0])
				loadQ.push_back({16'h00FF, 8'h00, 6'h30, m});
			bus(1, ulm_pkg::OFS_BUFFER, {6'h30, m}, 8'h00);
			chr(1'b0, m[1], 1'b0, m != 2'h3, 1'b0);
			// Whole status byte: one character waiting except in remote loop, transmitter flags per mode
			bus(0, ulm_pkg::OFS_STATUS_CMD, m[0] ? {7'h00, !m[1]} : {2'b00, m[1], 5'h0D},
				8'hFF);
			bus(0, ulm_pkg::OFS_BUFFER, m == 2'h3 ? 8'h00 : lastCh, 8'hFF);
		end
		// Break held on the output in echo and remote loop until a start bit
		for (int i = 1; i < 4; i += 2)
		begin
			m = i[1:0];
			bus(1, ulm_pkg::OFS_MODE_TWO, {m, 6'h00}, 8'h00);
			@(posedge clock);
			rxBreakDet <= 1'b1;
			@(posedge clock);
			rxBreakDet <= 1'b0;
			repeat (2) @(posedge clock);
			repeat (8) @(negedge clock)
				cmpBit(txdPin, 1'b0);
			@(posedge clock);
			rxStartDet <= 1'b1;
			@(posedge clock);
			rxStartDet <= 1'b0;
		end
		// Multidrop: tag bit in place of parity, address filter while disabled
		bus(1, ulm_pkg::OFS_STATUS_CMD, 8'h0A, 8'h00);
		bus(1, ulm_pkg::OFS_MODE_TWO, 8'h00, 8'h00);
		bus(1, ulm_pkg::OFS_MODE_ONE, 8'h1C, 8'h00);
		@(negedge clock);
		cmpBit(txParityGen, 1'b0);
		cmpBit(rxParityCheck, 1'b0);
		cmpBit(txTagSlot, 1'b1);
		cmpBit(txTagValue, 1'b1);
		bus(1, ulm_pkg::OFS_MODE_ONE, 8'h18, 8'h00);
		@(negedge clock);
		cmpBit(txTagValue, 1'b0);
		chr(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
		chr(1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
		bus(0, ulm_pkg::OFS_BUFFER, lastCh, 8'hFF);
		bus(1, ulm_pkg::OFS_STATUS_CMD, 8'h01, 8'h00);
		chr(1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
		bus(0, ulm_pkg::OFS_BUFFER, lastCh, 8'hFF);
		repeat (4) @(posedge clock);
		// Notes still waiting mean a result never appeared
		if (rdQ.size() + pushQ.size() + loadQ.size() + iackQ.size() != 0)
			mismatches++;
		give_verdict();
	end
endmodule // uart_loop_multidrop_modes_bench
`default_nettype wire
